// *** rtl/mti_top.sv ***
// How it works
// - Resume edge requests interrupted task continuation
// - Launch edge starts task on select lines
// - Launch with no task selected starts homing
// - Target reached high inside in-position window
// - Sequence step toggles at each chained start after the first
// - Sequence step low at chain's first task
// - Tracking fault low outside following window
// - Compare 1 defaults to travel limit 1
// - Compare 2 defaults to travel limit 2
// - Compare 0,3,4,5 set by config only
// - Fault clear edge sends a one-cycle warning clear request to the core
`timescale 1ns/1ps
`include "mti_defines.svh"
module mti_top (
	input  wire logic              clk_i,
	input  wire logic              rst_i,
	input  wire mti_pkg::mti_cmd_t  cmd_i,
	input  wire mti_pkg::mti_core_t core_i,
	output mti_pkg::mti_req_t       req_o,
	output logic                    target_reached_o,
	output logic                    seq_step_o,
	output logic                    tracking_fault_o,
	output logic [5:0]              pos_cmp_o,
	output logic                    irq_o,
	input  wire logic              wb_cyc_i,
	input  wire logic              wb_stb_i,
	input  wire logic              wb_we_i,
	input  wire logic [7:0]        wb_adr_i,
	input  wire logic [3:0]        wb_sel_i,
	input  wire logic [31:0]       wb_dat_i,
	output logic [31:0]             wb_dat_o,
	output logic                    wb_ack_o
);
	import mti_pkg::*;

	mti_state_t s;       // Registered state
	mti_state_t n;       // Next state
	logic       e_res;   // Resume edge
	logic       e_lau;   // Launch edge
	logic       e_clr;   // Fault clear edge
	logic       acc;     // Bus access this cycle
	logic       rd_stat; // Status read clears
	logic [3:0] ev;      // Events this cycle
	logic [1:0] src;     // Compare source code
	int         i;       // Loop index

	// Next-state logic
	always_comb begin
		n = s;
		src = `MTI_SRC_OFF;
		// Pins pass two flops; first flop feeds only the second
		n.s1 = cmd_i;
		n.s2 = s.s1;
		n.prev_resume = s.s2.resume;
		n.prev_launch = s.s2.launch;
		n.prev_clear = s.s2.fault_clear;
		// Rising edges give one pulse each
		e_res = s.s2.resume && !s.prev_resume;
		e_lau = s.s2.launch && !s.prev_launch;
		e_clr = s.s2.fault_clear && !s.prev_clear;
		n.req.resume = e_res;
		n.req.launch = e_lau;
		n.req.warn_clear = e_clr;
		n.req.homing = 1'b0;
		// Task number is latched at the launch edge
		if (e_lau) begin
			n.req.task_num = s.s2.task_sel;
			n.req.homing = (s.s2.task_sel == `MTI_TASK_NONE);
		end
		// Position status from the core
		n.tgt = core_i.in_window;
		n.trk = !core_i.follow_outside;
		// Sequence step output
		if (core_i.task_start && core_i.chain_active) begin
			if (core_i.chain_first) begin
				n.seq = 1'b0;
			end else begin
				n.seq = !s.seq;
			end
		end
		// Compare outputs follow their configured source
		for (i = 0; i < 6; i++) begin
			src = s.cfg[2*i +: 2];
			case (src)
				`MTI_SRC_LIM1: n.cmp[i] = core_i.sw_limit[0];
				`MTI_SRC_LIM2: n.cmp[i] = core_i.sw_limit[1];
				`MTI_SRC_EXT:  n.cmp[i] = core_i.cmp_ext[i];
				default:       n.cmp[i] = 1'b0;
			endcase
		end
		// Bus access, one wait state
		acc = wb_cyc_i && wb_stb_i && !s.ack;
		n.ack = acc;
		n.rdat = 32'h0000_0000;
		rd_stat = 1'b0;
		if (acc && !wb_we_i) begin
			if (wb_adr_i == `MTI_ADR_CFG) begin
				n.rdat[11:0] = s.cfg;
			end else if (wb_adr_i == `MTI_ADR_STAT) begin
				n.rdat[3:0] = s.stat;
				rd_stat = 1'b1;
			end else if (wb_adr_i == `MTI_ADR_MASK) begin
				n.rdat[3:0] = s.mask;
			end else if (wb_adr_i == `MTI_ADR_LIVE) begin
				n.rdat[7:0] = s.req.task_num;
				n.rdat[8] = s.tgt;
				n.rdat[9] = s.seq;
				n.rdat[10] = s.trk;
				n.rdat[21:16] = s.cmp;
			end
		end
		if (acc && wb_we_i) begin
			if (wb_adr_i == `MTI_ADR_CFG) begin
				if (wb_sel_i[0]) n.cfg[7:0] = wb_dat_i[7:0];
				if (wb_sel_i[1]) n.cfg[11:8] = wb_dat_i[11:8];
			end else if (wb_adr_i == `MTI_ADR_MASK) begin
				if (wb_sel_i[0]) n.mask = wb_dat_i[3:0];
			end
		end
		// Sticky events; a set wins over the read clear
		ev = 4'h0;
		ev[`MTI_ST_LAUNCH] = e_lau;
		ev[`MTI_ST_RESUME] = e_res;
		ev[`MTI_ST_HOMING] = e_lau && (s.s2.task_sel == `MTI_TASK_NONE);
		ev[`MTI_ST_TRACK] = s.trk && core_i.follow_outside;
		n.stat = (rd_stat ? 4'h0 : s.stat) | ev;
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.trk <= 1'b1;
			s.cfg <= `MTI_CFG_RST;
		end else begin
			s <= n;
		end
	end

	// Outputs
	assign req_o = s.req;
	assign target_reached_o = s.tgt;
	assign seq_step_o = s.seq;
	assign tracking_fault_o = s.trk;
	assign pos_cmp_o = s.cmp;
	assign irq_o = |(s.stat & s.mask);
	assign wb_dat_o = s.rdat;
	assign wb_ack_o = s.ack;

	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	launch_pulse_a: assert property (s.s2.launch && !s.prev_launch |=> req_o.launch ##1 !req_o.launch)
		else $error("launch edge did not give one pulse");
	launch_once_a: assert property (req_o.launch |=> !req_o.launch)
		else $error("launch request lasted two cycles");
	homing_sel_a: assert property (req_o.launch |-> req_o.homing == (req_o.task_num == `MTI_TASK_NONE))
		else $error("homing flag wrong for task number");
	task_latch_a: assert property (s.s2.launch && !s.prev_launch |=> req_o.task_num == $past(s.s2.task_sel))
		else $error("task number not latched at launch");
	resume_pulse_a: assert property (s.s2.resume && !s.prev_resume |=> req_o.resume ##1 !req_o.resume)
		else $error("resume edge did not give one pulse");
	clear_pulse_a: assert property (s.s2.fault_clear && !s.prev_clear |=> req_o.warn_clear)
		else $error("warning clear not issued");
	seq_first_a: assert property (core_i.task_start && core_i.chain_active && core_i.chain_first |=> !seq_step_o)
		else $error("sequence step not low at first task");
	seq_toggle_a: assert property (core_i.task_start && core_i.chain_active && !core_i.chain_first
		|=> seq_step_o != $past(seq_step_o))
		else $error("sequence step did not toggle");
	track_out_a: assert property (##1 tracking_fault_o == !$past(core_i.follow_outside))
		else $error("tracking fault level wrong");
	target_out_a: assert property (##1 target_reached_o == $past(core_i.in_window))
		else $error("target reached level wrong");
	cmp_lim1_a: assert property (s.cfg[3:2] == `MTI_SRC_LIM1 && $stable(s.cfg)
		|=> pos_cmp_o[1] == $past(core_i.sw_limit[0]))
		else $error("compare 1 not following limit 1");
	cmp_lim2_a: assert property (s.cfg[5:4] == `MTI_SRC_LIM2 && $stable(s.cfg)
		|=> pos_cmp_o[2] == $past(core_i.sw_limit[1]))
		else $error("compare 2 not following limit 2");
	ack_drop_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack held two cycles");

	launch_c: cover property (req_o.launch && !req_o.homing);
	homing_c: cover property (req_o.launch && req_o.homing);
	chain_c: cover property (core_i.task_start && core_i.chain_first ##[1:20] core_i.task_start && !core_i.chain_first);
	irq_c: cover property (irq_o ##[1:10] !irq_o);
endmodule

// *** rtl/mti_defines.svh ***
`ifndef MTI_DEFINES_SVH
`define MTI_DEFINES_SVH
// Register byte offsets
`define MTI_ADR_CFG     8'h00
`define MTI_ADR_STAT    8'h04
`define MTI_ADR_MASK    8'h08
`define MTI_ADR_LIVE    8'h0C
// Compare source codes, two bits per output
`define MTI_SRC_OFF     2'h0
`define MTI_SRC_LIM1    2'h1
`define MTI_SRC_LIM2    2'h2
`define MTI_SRC_EXT     2'h3
// Compare config reset value: output 1 on limit 1, output 2 on limit 2
`define MTI_CFG_RST     12'h0_24
// Task number that means no task selected
`define MTI_TASK_NONE   8'h00
// Status bit positions
`define MTI_ST_LAUNCH   0
`define MTI_ST_RESUME   1
`define MTI_ST_HOMING   2
`define MTI_ST_TRACK    3
`define MTI_ST_W        4
`endif

// *** rtl/mti_pkg.sv ***
package mti_pkg;
	// Command pins from the controller
	typedef struct packed {
		logic       resume;
		logic       launch;
		logic       fault_clear;
		logic [7:0] task_sel;
	} mti_cmd_t;
	// Signals from the drive core
	typedef struct packed {
		logic       in_window;
		logic       follow_outside;
		logic [1:0] sw_limit;
		logic [5:0] cmp_ext;
		logic       task_start;
		logic       chain_active;
		logic       chain_first;
	} mti_core_t;
	// Requests toward the drive core
	typedef struct packed {
		logic       resume;
		logic       launch;
		logic       homing;
		logic       warn_clear;
		logic [7:0] task_num;
	} mti_req_t;
	// Complete module state
	typedef struct packed {
		mti_cmd_t   s1;
		mti_cmd_t   s2;
		logic       prev_resume;
		logic       prev_launch;
		logic       prev_clear;
		mti_req_t   req;
		logic       seq;
		logic       tgt;
		logic       trk;
		logic [5:0] cmp;
		logic [11:0] cfg;
		logic [3:0] stat;
		logic [3:0] mask;
		logic       ack;
		logic [31:0] rdat;
	} mti_state_t;
endpackage

// *** tb/mti_plc.sv ***
`timescale 1ns/1ps
module mti_plc (
	input  wire logic         clk_i,
	output mti_pkg::mti_cmd_t cmd_o
);
	import mti_pkg::*;
	// All pins idle low
	initial cmd_o = '0;
	// Present a binary task number, let it settle, then raise launch
	task automatic launch(input logic [7:0] num);
		cmd_o.task_sel <= num;
		repeat (4) @(posedge clk_i);
		cmd_o.launch <= 1'b1;
		repeat (4) @(posedge clk_i);
		cmd_o.launch <= 1'b0;
	endtask
	// Hold resume and or clear high for a few cycles
	task automatic press(input logic res, input logic clr);
		cmd_o.resume      <= res;
		cmd_o.fault_clear <= clr;
		repeat (4) @(posedge clk_i);
		cmd_o.resume      <= 1'b0;
		cmd_o.fault_clear <= 1'b0;
	endtask
endmodule

// *** tb/tb_motion_task_io_interface.sv ***
`timescale 1ns/1ps
`include "mti_defines.svh"
module tb_motion_task_io_interface;
	import mti_pkg::*;
	logic        clk_i, rst_i, cyc, stb, we, ack, tgt, seq, trk, irq;
	logic [3:0]  sel;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat;
	logic [5:0]  cmp;
	mti_cmd_t    cmd;
	mti_core_t   core;
	mti_req_t    req;
	int          mismatches, cmp_count, n_l, n_h, n_r, n_c;
	mti_plc plc (.clk_i(clk_i), .cmd_o(cmd));
	mti_top uut (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .core_i(core), .req_o(req),
		.target_reached_o(tgt), .seq_step_o(seq), .tracking_fault_o(trk), .pos_cmp_o(cmp), .irq_o(irq),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack));
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	// Count one-cycle request pulses
	always @(posedge clk_i) begin
		n_l += req.launch;
		n_h += req.homing;
		n_r += req.resume;
		n_c += req.warn_clear;
	end
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d,
		output logic [31:0] r);
		int n;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		sel  <= s;
		wdat <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) begin
			mismatches++;
			report_and_stop();
		end
		@(posedge clk_i);
	endtask
	task automatic t_launch(input logic [7:0] num);
		n_l = 0;
		n_h = 0;
		plc.launch(num);
		repeat (4) @(posedge clk_i);
		chk(n_l, 1);
		chk(n_h, num == 8'h00);
		chk(req.task_num, num);
		$display("launch %h done", num);
	endtask
	task automatic t_press(input logic res, input logic clr);
		n_r = 0;
		n_c = 0;
		plc.press(res, clr);
		repeat (4) @(posedge clk_i);
		chk(n_r, res);
		chk(n_c, clr);
		$display("press done");
	endtask
	// Chained task start, first flag chosen by caller
	task automatic t_step(input logic first, input logic exp);
		core.task_start   <= 1'b1;
		core.chain_active <= 1'b1;
		core.chain_first  <= first;
		@(posedge clk_i);
		core.task_start <= 1'b0;
		repeat (2) @(posedge clk_i);
		chk(seq, exp);
		$display("step done");
	endtask
	initial begin
		logic [31:0] r;
		{cyc, stb, we, adr, sel, wdat} = '0;
		core  = '0;
		rst_i = 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_launch(8'h05);
		t_launch(8'h00);
		t_press(1'b1, 1'b0);
		t_press(1'b0, 1'b1);
		core.in_window      <= 1'b1;
		core.follow_outside <= 1'b1;
		core.sw_limit       <= 2'b01;
		repeat (2) @(posedge clk_i);
		chk(tgt, 1'b1);
		chk(trk, 1'b0);
		chk(cmp, 6'h02);
		core.in_window      <= 1'b0;
		core.follow_outside <= 1'b0;
		core.sw_limit       <= 2'b10;
		repeat (2) @(posedge clk_i);
		chk(tgt, 1'b0);
		chk(trk, 1'b1);
		chk(cmp, 6'h04);
		$display("core outputs done");
		t_step(1'b0, 1'b1);
		t_step(1'b1, 1'b0);
		t_step(1'b0, 1'b1);
		// Registers, interrupt and compare routing
		wb(1'b0, `MTI_ADR_CFG, 4'h0, 32'h0, r);
		chk(r, 32'h0000_0024);
		chk(irq, 1'b0);
		wb(1'b1, `MTI_ADR_MASK, 4'h1, 32'h0000_0001, r);
		chk(irq, 1'b1);
		wb(1'b0, `MTI_ADR_STAT, 4'h0, 32'h0, r);
		chk(r, 32'h0000_000F);
		chk(irq, 1'b0);
		wb(1'b1, `MTI_ADR_CFG, 4'h3, 32'h0000_0003, r);
		core.cmp_ext <= 6'h01;
		repeat (2) @(posedge clk_i);
		chk(cmp, 6'h01);
		// Live view: task 0, not on target, step high, no fault, compare 0 set
		wb(1'b0, `MTI_ADR_LIVE, 4'h0, 32'h0, r);
		chk(r, 32'h0001_0600);
		wb(1'b0, 8'h10, 4'h0, 32'h0, r);
		chk(r, 32'h0000_0000);
		$display("registers done");
		report_and_stop();
	end
endmodule
